//--- tmseq_fe_model.sv
// Behavioural front end that answers conversion requests
`timescale 1ns/1ps
module tmseq_fe_model (
    input wire logic clk_i,          // Core clock
    input wire logic rst_i,          // Sync reset, high
    input wire logic conv_req_i,     // Request level
    input wire logic [11:0] val_i,   // Result to hand back
    input wire logic [3:0] wait_i,   // Answer delay, cycles
    output logic conv_done_o,        // Done level
    output logic [11:0] conv_data_o  // Result
);
    logic [4:0] cnt_q;
    // ==========================================================
    // Handshake
    // ==========================================================
    // Data settles a cycle before done; done held until request drops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_done_o <= 1'b0;
            cnt_q <= 5'h00;
            conv_data_o <= 12'h000;
        end else if (!conv_req_i) begin
            conv_done_o <= 1'b0;
            cnt_q <= 5'h00;
            if (!conv_done_o) begin
                conv_data_o <= ~conv_data_o; // Churns so stale data is never read
            end
        end else if (!conv_done_o) begin
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == {1'b0, wait_i}) begin
                conv_data_o <= val_i;
            end
            if (cnt_q == {1'b0, wait_i} + 5'h01) begin
                conv_done_o <= 1'b1;
            end
        end
    end
endmodule

//--- tmseq_pkg.sv
// Shared constants and types of the temperature monitor sequencer
package tmseq_pkg;
    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_KHZ = 40000;                        // 40 MHz core clock
    localparam int T_LOCAL_MS = 15;                        // Local sensor slot
    localparam int T_REMOTE_MS = 44;                       // Remote slot, no cancel
    localparam int T_REMOTE_RC_MS = 93;                    // Remote slot, cancel on
    localparam int LOCAL_CYC_DEF = T_LOCAL_MS * CLK_KHZ;
    localparam int REMOTE_CYC_DEF = T_REMOTE_MS * CLK_KHZ;
    localparam int REMOTE_RC_CYC_DEF = T_REMOTE_RC_MS * CLK_KHZ;
    localparam logic [8:0] DELAY_STEP = 9'h020;            // Cycles per delay step
    // ==========================================================
    // Register map (byte addresses)
    // ==========================================================
    localparam logic [7:0] ADR_CFG = 8'h00;
    localparam logic [7:0] ADR_IDEAL = 8'h04;
    localparam logic [7:0] ADR_STAT = 8'h08;
    localparam logic [7:0] ADR_DATA_LOCAL = 8'h0C;
    localparam logic [7:0] ADR_DATA_REM1 = 8'h10;
    localparam logic [7:0] ADR_DATA_REM2 = 8'h14;
    // ==========================================================
    // Fields and reset values
    // ==========================================================
    localparam int CFG_LOCAL_EN = 0;                       // local_sensor_enable
    localparam int CFG_REM1_EN = 1;                        // remote_one_enable
    localparam int CFG_REM2_EN = 2;                        // remote_two_enable
    localparam int CFG_RC = 3;                             // resistance_cancel_enable
    localparam int CFG_DLY_EN = 4;
    localparam int CFG_DLY_LSB = 5;
    localparam logic [7:0] CFG_RST = 8'h07;
    localparam logic [7:0] IDEAL_RST = 8'h00;
    localparam logic [8:0] DEN_BASE = 9'h12C;              // 300
    // ==========================================================
    // Enumerations
    // ==========================================================
    typedef enum logic [1:0] {
        SNS_LOCAL = 2'b00,
        SNS_REM1 = 2'b01,
        SNS_REM2 = 2'b10,
        SNS_END = 2'b11
    } tmseq_sensor_e;
    typedef enum logic {
        ST_PICK = 1'b0,
        ST_SLOT = 1'b1
    } tmseq_state_e;
endpackage

//--- tmseq_top.sv
// Temperature monitor sequencer with classic Wishbone register slave
//
// Overview of operation
// - After reset the ideality correction is zero, meaning ideality 1.008.
// - Correction is one signed twos-complement byte, -128 to +127.
// - Effective ideality is 1.008*300/(300-correction), sent as denominator.
// - Series-resistance cancellation only on remote conversions while its bit is set.
// - Every result is a 12-bit value for every sensor.
// - Finished result goes to its data register; deferred while that register is read.
// - Local sensor alone gives a 15 ms monitoring cycle.
// - One remote sensor alone: 44 ms, or 93 ms with cancellation.
// - One remote plus local: 59 ms, or 108 ms with cancellation.
// - Both remotes: 88 ms, or 186 ms with cancellation.
// - All three sensors: 103 ms, or 201 ms with cancellation.
// - Programmable delay of 32 to 256 cycle times between active cycles.
// - Each sensor has an enable; disabled sensors are skipped.
// - A finished cycle starts the next one automatically.
// - Results are twos complement with 0.125 degree steps.
`timescale 1ns/1ps
module tmseq_top import tmseq_pkg::*; #(
    parameter int LOCAL_CYC = LOCAL_CYC_DEF,
    parameter int REMOTE_CYC = REMOTE_CYC_DEF,
    parameter int REMOTE_RC_CYC = REMOTE_RC_CYC_DEF,
    parameter int CNT_W = 24
) (
    input logic clk_i,                     // Core clock
    input logic rst_i,                     // Sync reset, high
    input logic wb_cyc_i,                  // Bus cycle
    input logic wb_stb_i,                  // Strobe
    input logic wb_we_i,                   // Write enable
    input logic [7:0] wb_adr_i,            // Byte address
    input logic [3:0] wb_sel_i,            // Byte lanes
    input logic [31:0] wb_dat_i,           // Write data
    output logic [31:0] wb_dat_o,          // Read data
    output logic wb_ack_o,                 // Acknowledge
    output logic conv_req_o,               // Conversion request level
    output logic [1:0] conv_sel_o,         // Sensor being converted
    output logic conv_rc_o,                // Cancellation for this one
    output logic [8:0] conv_den_o,         // 300 minus correction
    input logic conv_done_i,               // Front end done level
    input logic [11:0] conv_data_i         // Filtered result
);
    // ==========================================================
    // Parameter checks
    // ==========================================================
    // Counter must hold the longest slot
    if (CNT_W > 31 || LOCAL_CYC < 2 || REMOTE_CYC < 2 || REMOTE_RC_CYC < 2 ||
        LOCAL_CYC >= 2**CNT_W || REMOTE_CYC >= 2**CNT_W ||
        REMOTE_RC_CYC >= 2**CNT_W) begin : g_bad_param
        $error("tmseq_top: slot lengths do not fit the counter");
    end

    // ==========================================================
    // Registers and state
    // ==========================================================
    logic [7:0] cfg_q;
    logic [7:0] ideal_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic [12:0] s1_q, s2_q, s3_q, filt_q;
    tmseq_state_e state_q;
    logic [1:0] try_q;
    logic [1:0] sel_q;
    logic [CNT_W-1:0] cnt_q;
    logic req_q;
    logic rc_q;
    logic [8:0] den_q;
    logic [8:0] idle_left_q;
    logic [7:0] cycles_q;
    logic [11:0] res_q [3];
    logic [11:0] pval_q [3];
    logic [2:0] pend_q;

    // ==========================================================
    // Bus decode
    // ==========================================================
    // A request is live until its ack; one wait state per access
    wire bus_act = wb_cyc_i & wb_stb_i;
    wire bus_req = bus_act & ~ack_q;
    wire wr_ok = bus_req & wb_we_i & wb_sel_i[0];
    wire wr_cfg = wr_ok & (wb_adr_i == ADR_CFG);
    wire wr_ideal = wr_ok & (wb_adr_i == ADR_IDEAL);
    wire rd_act = bus_act & ~wb_we_i;
    // Hold covers the whole read, ack cycle included
    wire [2:0] rd_hit = {rd_act & (wb_adr_i == ADR_DATA_REM2),
                         rd_act & (wb_adr_i == ADR_DATA_REM1),
                         rd_act & (wb_adr_i == ADR_DATA_LOCAL)};
    wire [31:0] stat_w = {16'h0000, cycles_q, 3'b000, idle_left_q != 9'h000, req_q,
                          state_q == ST_SLOT, sel_q};
    // Unmapped addresses read as zero and are still acknowledged
    wire [31:0] rd_mux =
        (wb_adr_i == ADR_CFG) ? {24'h00_0000, cfg_q} :
        (wb_adr_i == ADR_IDEAL) ? {24'h00_0000, ideal_q} :
        (wb_adr_i == ADR_STAT) ? stat_w :
        (wb_adr_i == ADR_DATA_LOCAL) ? {20'h0_0000, res_q[0]} :
        (wb_adr_i == ADR_DATA_REM1) ? {20'h0_0000, res_q[1]} :
        (wb_adr_i == ADR_DATA_REM2) ? {20'h0_0000, res_q[2]} : 32'h0000_0000;

    // Bus answer and writable registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
            cfg_q <= CFG_RST;
            ideal_q <= IDEAL_RST;
        end else begin
            ack_q <= bus_req;
            rdat_q <= bus_req ? rd_mux : 32'h0000_0000;
            if (wr_cfg) cfg_q <= wb_dat_i[7:0];
            if (wr_ideal) ideal_q <= wb_dat_i[7:0];
        end
    end

    // ==========================================================
    // Front end input synchroniser
    // ==========================================================
    // Data settles before done rises, so per-bit filtering is safe
    wire [12:0] filt_d = (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= 13'h0000;
            s2_q <= 13'h0000;
            s3_q <= 13'h0000;
            filt_q <= 13'h0000;
        end else begin
            s1_q <= {conv_done_i, conv_data_i};
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= filt_d;
        end
    end
    wire done_w = filt_q[12];
    wire [11:0] data_w = filt_q[11:0];

    // ==========================================================
    // Sequencer decode
    // ==========================================================
    wire [3:0] en_v = {1'b0, cfg_q[CFG_REM2_EN], cfg_q[CFG_REM1_EN], cfg_q[CFG_LOCAL_EN]};
    wire try_en = en_v[try_q];
    wire at_end = (try_q == SNS_END);
    wire any_en = |cfg_q[CFG_REM2_EN:CFG_LOCAL_EN];
    wire remote = (try_q != SNS_LOCAL);
    wire idle_ph = (idle_left_q != 9'h000);
    wire slot_load = (state_q == ST_PICK) & ~at_end & try_en;
    wire cyc_end = (state_q == ST_PICK) & at_end;
    // Slot also waits for the handshake to close, so a slow front end stretches it
    wire slot_done = (state_q == ST_SLOT) & (cnt_q == '0) & ~req_q & ~done_w;
    wire new_ev = (state_q == ST_SLOT) & req_q & done_w;
    // Slot lengths add up to the cycle times of every configuration
    wire [CNT_W-1:0] slot_len = !remote ? CNT_W'(LOCAL_CYC - 1) :
        cfg_q[CFG_RC] ? CNT_W'(REMOTE_RC_CYC - 1) : CNT_W'(REMOTE_CYC - 1);
    wire [8:0] den_d = DEN_BASE - {ideal_q[7], ideal_q};
    wire [8:0] dly_len = 9'({6'h00, cfg_q[CFG_DLY_LSB +: 3]} + 9'h001) * DELAY_STEP;

    // Slot state machine, fixed order by index
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_PICK;
            try_q <= SNS_LOCAL;
            sel_q <= SNS_LOCAL;
            cnt_q <= '0;
            req_q <= 1'b0;
            rc_q <= 1'b0;
            den_q <= DEN_BASE;
        end else begin
            unique case (state_q)
                ST_PICK: begin
                    if (at_end) begin
                        try_q <= SNS_LOCAL;
                    end else if (try_en) begin
                        state_q <= ST_SLOT;
                        sel_q <= try_q;
                        cnt_q <= slot_len;
                        req_q <= ~idle_ph;
                        rc_q <= cfg_q[CFG_RC] & remote;
                        den_q <= den_d;
                    end else begin
                        try_q <= try_q + 2'b01;
                    end
                end
                ST_SLOT: begin
                    if (cnt_q != '0) cnt_q <= cnt_q - 1'b1;
                    if (new_ev) req_q <= 1'b0;
                    if (slot_done) begin
                        state_q <= ST_PICK;
                        try_q <= sel_q + 2'b01;
                    end
                end
            endcase
        end
    end

    // Delay between active cycles, counted in whole cycle times
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            idle_left_q <= 9'h000;
            cycles_q <= 8'h00;
        end else if (cyc_end & any_en) begin
            if (!idle_ph) cycles_q <= cycles_q + 8'h01;
            if (idle_ph) idle_left_q <= idle_left_q - 9'h001;
            else if (cfg_q[CFG_DLY_EN]) idle_left_q <= dly_len;
        end
    end

    // ==========================================================
    // Result registers
    // ==========================================================
    // A read in progress freezes the register; newest result waits aside
    for (genvar i = 0; i < 3; i++) begin : g_res
        wire new_i = new_ev & (sel_q == 2'(i));
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                res_q[i] <= 12'h000;
                pval_q[i] <= 12'h000;
                pend_q[i] <= 1'b0;
            end else if (rd_hit[i]) begin
                if (new_i) begin
                    pval_q[i] <= data_w;
                    pend_q[i] <= 1'b1;
                end
            end else begin
                if (new_i) res_q[i] <= data_w;
                else if (pend_q[i]) res_q[i] <= pval_q[i];
                pend_q[i] <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign conv_req_o = req_q;
    assign conv_sel_o = sel_q;
    assign conv_rc_o = rc_q;
    assign conv_den_o = den_q;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_wrap;
        cyc_end && any_en;
    endsequence
    sequence s_next_slot;
        ##[1:3] slot_load;
    endsequence
    property p_restart;
        s_wrap |-> s_next_slot;
    endproperty

    a_ideal_por: assert property ($fell(rst_i) |-> ideal_q == 8'h00 && den_q == 9'h12C)
        else $error("correction not zero after reset");
    a_den_eff: assert property (slot_load |=> conv_den_o ==
        9'(9'd300 - {$past(ideal_q[7]), $past(ideal_q)}))
        else $error("denominator does not follow correction");
    a_rc_gate: assert property (slot_load |=>
        conv_rc_o == ($past(cfg_q[CFG_RC]) && conv_sel_o != SNS_LOCAL))
        else $error("cancellation flag wrong");
    a_hold_data: assert property (rd_hit[1] |=> $stable(res_q[1]))
        else $error("data register changed during read");
    a_pend_flush: assert property (pend_q[0] && !rd_hit[0] |=>
        !pend_q[0] && res_q[0] == $past(pval_q[0]))
        else $error("deferred result not written");
    a_slot_local: assert property (slot_load && try_q == SNS_LOCAL |=>
        cnt_q == CNT_W'(LOCAL_CYC - 1))
        else $error("local slot length wrong");
    a_slot_remote: assert property (slot_load && try_q != SNS_LOCAL |=>
        cnt_q == ($past(cfg_q[CFG_RC]) ? CNT_W'(REMOTE_RC_CYC - 1) : CNT_W'(REMOTE_CYC - 1)))
        else $error("remote slot length wrong");
    a_delay_load: assert property (s_wrap and !idle_ph && cfg_q[CFG_DLY_EN] |=>
        idle_left_q == 9'(($past(cfg_q[7:5]) + 9'd1) * 9'd32))
        else $error("delay length wrong");
    // Judge the enable at the pick cycle, where try_q names the sensor taken
    a_skip_off: assert property ($rose(conv_req_o) |->
        $past(en_v[try_q]) && conv_sel_o == $past(try_q))
        else $error("disabled sensor converted");
    a_restart: assert property (p_restart)
        else $error("next cycle did not start");
    a_result_w: assert property (wb_ack_o && $past(|rd_hit) |-> wb_dat_o[31:12] == 20'h0)
        else $error("result wider than 12 bits");
    a_full_res: assert property ($changed(res_q[0]) |->
        $past(new_ev && sel_q == SNS_LOCAL) || $past(pend_q[0]))
        else $error("result stored without a completed conversion");
    a_hold_local: assert property (rd_hit[0] |=> $stable(res_q[0]))
        else $error("local data register changed during read");
    a_hold_rem2: assert property (rd_hit[2] |=> $stable(res_q[2]))
        else $error("remote two data register changed during read");
    // An idle slot keeps the front end quiet
    a_idle_quiet: assert property (slot_load && idle_ph |=> !conv_req_o)
        else $error("request raised during delay");
    a_ideal_take: assert property (wr_ideal |=> ideal_q == $past(wb_dat_i[7:0]))
        else $error("correction write lost");
    // Only active cycles advance the cycle counter
    a_cycle_cnt: assert property (s_wrap and !idle_ph |=>
        cycles_q == $past(cycles_q) + 8'h01)
        else $error("active cycle not counted");
endmodule

//--- tmseq_top_tb_top.sv
// Self-checking bench for the temperature monitor sequencer
`timescale 1ns/1ps
module tmseq_top_tb_top import tmseq_pkg::*; ;
    localparam int LC = 20;
    localparam int RC = 40;
    localparam int RRC = 80;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic conv_req_o;
    logic conv_rc_o;
    logic conv_done_i;
    logic [1:0] conv_sel_o;
    logic [8:0] conv_den_o;
    logic [11:0] conv_data_i;
    logic [11:0] vals [3] = '{default: 12'h000};
    logic [3:0] wait_q = 4'h0;
    logic [31:0] seed = 32'h2589_bcb7;
    logic [31:0] exp_q [$];
    int error_cnt = 0;
    int num_checks = 0;
    int cyc_cnt = 0;
    // ==========================================================
    // Design, front end and clock
    // ==========================================================
    tmseq_top #(.LOCAL_CYC(LC), .REMOTE_CYC(RC), .REMOTE_RC_CYC(RRC)) u_tmseq_top (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conv_req_o(conv_req_o),
        .conv_sel_o(conv_sel_o), .conv_rc_o(conv_rc_o), .conv_den_o(conv_den_o),
        .conv_done_i(conv_done_i), .conv_data_i(conv_data_i));
    tmseq_fe_model u_tmseq_fe_model (.clk_i(clk_i), .rst_i(rst_i), .conv_req_i(conv_req_o),
        .val_i(vals[conv_sel_o]), .wait_i(wait_q), .conv_done_o(conv_done_i),
        .conv_data_o(conv_data_i));
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("Totals: %0d checks, %0d mismatches", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // One classic cycle; waits for ack, bounded so a dead slave cannot hang us
    task automatic wb_acc(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                          input logic [3:0] sel);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= sel;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) error_cnt++;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task automatic wb_rd(input logic [7:0] adr, input logic [31:0] exp);
        exp_q.push_back(exp);
        wb_acc(1'b0, adr, 32'h0000_0000, 4'hF);
    endtask
    // Read data checked against the oldest note; also the hang limit
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (wb_ack_o === 1'b1 && !wb_we_i && exp_q.size() > 0) begin
            chk(wb_dat_o, exp_q.pop_front());
        end
        if (cyc_cnt == 40000) begin
            error_cnt++;
            stop_test();
        end
    end
    // ==========================================================
    // Sequencing expectations
    // ==========================================================
    // Monitoring cycles per period: the active one plus the idle ones
    function automatic int ncyc(input logic [7:0] c);
        return c[4] ? 1 + (int'(c[7:5]) + 1) * int'(DELAY_STEP) : 1;
    endfunction
    function automatic int period(input logic [7:0] c);
        int p;
        p = (c[0] ? LC : 0) + (int'(c[1]) + int'(c[2])) * (c[3] ? RRC : RC);
        return p * ncyc(c);
    endfunction
    function automatic logic [1:0] nxt(input logic [7:0] c, input logic [1:0] s);
        logic [1:0] n;
        n = s;
        for (int k = 0; k < 3; k++) begin
            n = (n == 2'h2) ? 2'h0 : n + 2'h1;
            if (c[n]) return n;
        end
        return s;
    endfunction
    // Skips the cycle in flight and the next one, then checks each request and one full period
    task automatic run_cfg(input logic [7:0] c, input logic [7:0] idl);
        logic pr;
        logic [1:0] s;
        int syncs;
        int t0;
        int n;
        int lim;
        pr = 1'b1;
        s = 2'h2;
        syncs = 0;
        t0 = 0;
        n = 0;
        lim = 5 * period(c) + 1000;
        while (syncs < 4 && n < lim) begin
            @(posedge clk_i);
            n++;
            if (conv_req_o === 1'b1 && !pr) begin
                if (conv_sel_o === nxt(c, 2'h2)) syncs++;
                if (syncs >= 2) begin
                    chk(32'(conv_sel_o), 32'(nxt(c, s)));
                    chk(32'(conv_rc_o), 32'(c[3] & (conv_sel_o != 2'h0)));
                    chk(32'(conv_den_o), 32'(int'(DEN_BASE) - int'($signed(idl))));
                    s = conv_sel_o;
                end
                if (conv_sel_o === nxt(c, 2'h2) && syncs == 3) t0 = n;
                if (conv_sel_o === nxt(c, 2'h2) && syncs == 4) begin
                    chk(32'(n - t0 >= period(c) && n - t0 <= period(c) + 5 * ncyc(c)),
                        32'h1);
                end
            end
            pr = conv_req_o;
        end
        if (n >= lim) error_cnt++;
    endtask
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        logic [7:0] cfgs [12];
        logic [7:0] idl;
        logic [1:0] f;
        cfgs = '{8'h01, 8'h02, 8'h0A, 8'h03, 8'h0B, 8'h06, 8'h0E, 8'h07, 8'h0F, 8'h04,
                 8'h11, 8'hF1};
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(32'(conv_den_o), 32'(DEN_BASE));
        wb_rd(ADR_DATA_LOCAL, 32'h0000_0000);
        wb_rd(ADR_CFG, {24'h00_0000, CFG_RST});
        wb_rd(ADR_IDEAL, 32'h0000_0000);
        wb_rd(ADR_DATA_REM2, 32'h0000_0000);
        wb_rd(8'h40, 32'h0000_0000);
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            idl = (i == 0) ? 8'h7F : (i == 1) ? 8'h80 : seed[7:0];
            wait_q <= {1'b0, seed[10:8]};
            vals[0] <= seed[23:12];
            vals[1] <= seed[31:20] ^ 12'h5A5;
            vals[2] <= ~seed[19:8];
            wb_acc(1'b1, ADR_IDEAL, {24'h00_0000, idl}, 4'hF);
            wb_acc(1'b1, ADR_CFG, {24'h00_0000, cfgs[i]}, 4'hF);
            run_cfg(cfgs[i], idl);
            // Time a read of the first sensor so its new result must wait aside
            f = nxt(cfgs[i], 2'h2);
            repeat (int'(wait_q) + 3) @(posedge clk_i);
            wb_rd(ADR_DATA_LOCAL + 8'(4 * f), {20'h0_0000, vals[f]});
            for (int k = 0; k < 3; k++) begin
                if (cfgs[i][k]) wb_rd(ADR_DATA_LOCAL + 8'(4 * k), {20'h0_0000, vals[k]});
            end
        end
        wb_acc(1'b1, ADR_IDEAL, 32'h0000_0055, 4'h0);
        wb_rd(ADR_IDEAL, {24'h00_0000, idl});
        repeat (2) @(posedge clk_i);
        stop_test();
    end
endmodule
